// ---- design/cpc_pkg.sv ----
package cpc_pkg;

   // ****************************************************************
   // bus geometry
   // ****************************************************************
   localparam int          ADR_W        = 12;
   localparam int          IDX_W        = 10;

   // register indices, byte address is four times the index
   localparam logic [9:0]  IDX_PLL_CTRL = 10'h010;
   localparam logic [9:0]  IDX_RDIV_LO  = 10'h011;
   localparam logic [9:0]  IDX_RDIV_HI  = 10'h012;
   localparam logic [9:0]  IDX_ABL_CTRL = 10'h017;
   localparam logic [9:0]  IDX_CAL_CTRL = 10'h018;
   localparam logic [9:0]  IDX_PUMP_CUR = 10'h01A;
   localparam logic [9:0]  IDX_STATUS   = 10'h01F;
   localparam logic [9:0]  IDX_VCO_DIV  = 10'h1E0;
   localparam logic [9:0]  IDX_DIST_SEL = 10'h1E1;
   localparam logic [9:0]  IDX_UPDATE   = 10'h232;

   // ****************************************************************
   // writable bit masks (reserved bits read zero)
   // ****************************************************************
   localparam logic [7:0]  MSK_PLL_CTRL = 8'hF3;
   localparam logic [7:0]  MSK_RDIV_LO  = 8'hFF;
   localparam logic [7:0]  MSK_RDIV_HI  = 8'h3F;
   localparam logic [7:0]  MSK_ABL_CTRL = 8'h03;
   localparam logic [7:0]  MSK_CAL_CTRL = 8'h01;
   localparam logic [7:0]  MSK_PUMP_CUR = 8'h07;
   localparam logic [7:0]  MSK_VCO_DIV  = 8'h07;
   localparam logic [7:0]  MSK_DIST_SEL = 8'h03;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int          POWER_LSB    = 0;
   localparam int          MODE_LSB     = 4;
   localparam int          POL_BIT      = 7;
   localparam int          CAL_BIT      = 0;
   localparam int          BYPASS_BIT   = 0;
   localparam int          SRC_BIT      = 1;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0]  RST_PLL_CTRL = 8'h01;
   localparam logic [7:0]  RST_VCO_DIV  = 8'h02;
   localparam logic [7:0]  RST_ZERO     = 8'h00;

   // ****************************************************************
   // codes
   // ****************************************************************
   localparam logic [1:0]  PWR_NORMAL   = 2'h0;
   localparam logic [1:0]  PWR_DOWN     = 2'h1;
   localparam logic [7:0]  UPDATE_CMD   = 8'h01;
   localparam logic [2:0]  CP_HIZ       = 3'h0;
   localparam logic [2:0]  CP_NORMAL    = 3'h1;
   localparam logic [2:0]  CP_PUMP_UP   = 3'h2;
   localparam logic [2:0]  CP_PUMP_DOWN = 3'h3;
   localparam logic [2:0]  VDIV_MAX     = 3'h4;
   localparam logic [2:0]  VDIV_OFFSET  = 3'h2;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int          CLK_HZ       = 20_000_000;
   localparam int          CAL_CYCLES   = 1024;

   typedef struct packed {
      logic [7:0] pll_ctrl;
      logic [7:0] rdiv_lo;
      logic [7:0] rdiv_hi;
      logic [7:0] abl_ctrl;
      logic [7:0] cal_ctrl;
      logic [7:0] pump_cur;
      logic [7:0] vco_div;
      logic [7:0] dist_sel;
   } cpc_cfg_t;

   localparam cpc_cfg_t CFG_RESET = '{pll_ctrl: RST_PLL_CTRL, rdiv_lo: RST_ZERO, rdiv_hi: RST_ZERO,
                                      abl_ctrl: RST_ZERO, cal_ctrl: RST_ZERO, pump_cur: RST_ZERO,
                                      vco_div: RST_VCO_DIV, dist_sel: RST_ZERO};

endpackage

// ---- design/cpc_event_divider.sv ----
`timescale 1ns/1ps
module cpc_event_divider #(
   parameter int W = 14
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // events in, ratio
   input  wire logic         tick_i,
   input  wire logic [W-1:0] ratio_i,
   // divided event out
   output logic              pulse_o
);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         pulse_q;
   logic         pulse_d;
   logic [W-1:0] term;

   always_comb begin
      // ratio zero and one both divide by one
      term    = (ratio_i <= W'(1)) ? '0 : ratio_i - W'(1);
      cnt_d   = cnt_q;
      pulse_d = 1'b0;
      if (tick_i) begin
         if (cnt_q >= term) begin
            cnt_d   = '0;
            pulse_d = 1'b1;
         end else begin
            cnt_d = cnt_q + W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q   <= '0;
         pulse_q <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         pulse_q <= pulse_d;
      end
   end

   assign pulse_o = pulse_q;

endmodule

// ---- design/cpc_clock_path_ctrl.sv ----
`timescale 1ns/1ps
// Overview of operation
// - power field 00b runs the PLL, 01b powers it down synchronously
// - bypass bit clear uses the VCO divider output, set bypasses it
// - source bit clear routes external clock, set routes on-chip VCO
// - three-bit VCO divider code selects ratio two through six
// - calibration starts when bit committed as one; clear and commit before recalibrating
// - settings take effect only after 0x01 is written to the update register
// - polarity bit clear is positive, set is negative
// - polarity only matters with external VCO; ignored with on-chip VCO
// - two-bit field selects antibacklash pulse width
// - pump mode selects high impedance, normal, constant up or constant down
// - pump current selectable in eight equal steps
// - detector compares reference and feedback pulses and drives pump up or down
// - reference divider is 14 bits; values zero and one divide by one
// - reset gives divide by four, PLL powered down, external clock selected
module cpc_clock_path_ctrl #(
   parameter int CAL_LEN = cpc_pkg::CAL_CYCLES
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // clock path events
   input  wire logic        ref_tick_i,
   input  wire logic        fb_tick_i,
   input  wire logic        ext_clk_tick_i,
   input  wire logic        vco_tick_i,
   input  wire logic        ref_present_i,
   // clock path controls
   output logic             pll_power_down_o,
   output logic             vco_select_o,
   output logic             div_bypass_o,
   output logic      [2:0]  vco_div_code_o,
   output logic             dist_tick_o,
   // detector and pump
   output logic             pump_up_o,
   output logic             pump_down_o,
   output logic             pump_hiz_o,
   output logic      [2:0]  pump_current_o,
   output logic      [1:0]  antibacklash_o,
   // calibration
   output logic             cal_run_o,
   output logic             cal_done_o
);

   // ****************************************************************
   // bus slave
   // ****************************************************************
   logic                ack_q;
   logic                ack_d;
   logic [31:0]         rdat_q;
   logic [31:0]         rdat_d;
   logic                wr;
   logic                commit;
   logic [9:0]          idx;
   logic [7:0]          wbyte;
   cpc_pkg::cpc_cfg_t   sh_q;
   cpc_pkg::cpc_cfg_t   sh_d;
   cpc_pkg::cpc_cfg_t   act_q;
   cpc_pkg::cpc_cfg_t   act_d;
   logic [7:0]          status;

   always_comb begin
      idx    = wb_adr_i[11:2];
      wbyte  = wb_dat_i[7:0];
      ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
      wr     = ack_d & wb_we_i & wb_sel_i[0];
      commit = wr && (idx == cpc_pkg::IDX_UPDATE) && (wbyte == cpc_pkg::UPDATE_CMD);
      rdat_d = rdat_q;
      if (ack_d) begin
         rdat_d = 32'h0000_0000;
         unique case (idx)
            cpc_pkg::IDX_PLL_CTRL: rdat_d[7:0] = sh_q.pll_ctrl;
            cpc_pkg::IDX_RDIV_LO:  rdat_d[7:0] = sh_q.rdiv_lo;
            cpc_pkg::IDX_RDIV_HI:  rdat_d[7:0] = sh_q.rdiv_hi;
            cpc_pkg::IDX_ABL_CTRL: rdat_d[7:0] = sh_q.abl_ctrl;
            cpc_pkg::IDX_CAL_CTRL: rdat_d[7:0] = sh_q.cal_ctrl;
            cpc_pkg::IDX_PUMP_CUR: rdat_d[7:0] = sh_q.pump_cur;
            cpc_pkg::IDX_STATUS:   rdat_d[7:0] = status;
            cpc_pkg::IDX_VCO_DIV:  rdat_d[7:0] = sh_q.vco_div;
            cpc_pkg::IDX_DIST_SEL: rdat_d[7:0] = sh_q.dist_sel;
            default:               rdat_d[7:0] = 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // shadow and active settings
   // ****************************************************************
   always_comb begin
      sh_d = sh_q;
      if (wr) begin
         unique case (idx)
            cpc_pkg::IDX_PLL_CTRL: sh_d.pll_ctrl = wbyte & cpc_pkg::MSK_PLL_CTRL;
            cpc_pkg::IDX_RDIV_LO:  sh_d.rdiv_lo  = wbyte & cpc_pkg::MSK_RDIV_LO;
            cpc_pkg::IDX_RDIV_HI:  sh_d.rdiv_hi  = wbyte & cpc_pkg::MSK_RDIV_HI;
            cpc_pkg::IDX_ABL_CTRL: sh_d.abl_ctrl = wbyte & cpc_pkg::MSK_ABL_CTRL;
            cpc_pkg::IDX_CAL_CTRL: sh_d.cal_ctrl = wbyte & cpc_pkg::MSK_CAL_CTRL;
            cpc_pkg::IDX_PUMP_CUR: sh_d.pump_cur = wbyte & cpc_pkg::MSK_PUMP_CUR;
            cpc_pkg::IDX_VCO_DIV:  sh_d.vco_div  = wbyte & cpc_pkg::MSK_VCO_DIV;
            cpc_pkg::IDX_DIST_SEL: sh_d.dist_sel = wbyte & cpc_pkg::MSK_DIST_SEL;
            default:               sh_d = sh_q;
         endcase
      end
      // pending values move to the active set in one step
      act_d = commit ? sh_q : act_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
         sh_q   <= cpc_pkg::CFG_RESET;
         act_q  <= cpc_pkg::CFG_RESET;
      end else begin
         ack_q  <= ack_d;
         rdat_q <= rdat_d;
         sh_q   <= sh_d;
         act_q  <= act_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ****************************************************************
   // decoded active settings
   // ****************************************************************
   logic        pll_off;
   logic        use_vco;
   logic        bypass;
   logic        pol_neg;
   logic [2:0]  cp_mode;
   logic [2:0]  vdiv_ratio;
   logic [13:0] rdiv_ratio;
   logic [2:0]  abl_len;

   always_comb begin
      pll_off    = act_q.pll_ctrl[cpc_pkg::POWER_LSB +: 2] != cpc_pkg::PWR_NORMAL;
      use_vco    = act_q.dist_sel[cpc_pkg::SRC_BIT];
      bypass     = act_q.dist_sel[cpc_pkg::BYPASS_BIT];
      pol_neg    = act_q.pll_ctrl[cpc_pkg::POL_BIT] & ~use_vco;
      cp_mode    = act_q.pll_ctrl[cpc_pkg::MODE_LSB +: 3];
      // codes above the top ratio saturate at divide by six
      if (act_q.vco_div[2:0] > cpc_pkg::VDIV_MAX) begin
         vdiv_ratio = cpc_pkg::VDIV_MAX + cpc_pkg::VDIV_OFFSET;
      end else begin
         vdiv_ratio = act_q.vco_div[2:0] + cpc_pkg::VDIV_OFFSET;
      end
      rdiv_ratio = {act_q.rdiv_hi[5:0], act_q.rdiv_lo};
      abl_len    = {1'b0, act_q.abl_ctrl[1:0]} + 3'h1;
   end

   // ****************************************************************
   // dividers
   // ****************************************************************
   logic src_tick;
   logic vdiv_pulse;
   logic ref_pulse;
   logic dist_q;
   logic dist_d;

   assign src_tick = use_vco ? vco_tick_i : ext_clk_tick_i;

   cpc_event_divider #(.W(3)) u_vco_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .tick_i  (src_tick),
      .ratio_i (vdiv_ratio),
      .pulse_o (vdiv_pulse)
   );

   cpc_event_divider #(.W(14)) u_ref_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .tick_i  (ref_tick_i),
      .ratio_i (rdiv_ratio),
      .pulse_o (ref_pulse)
   );

   always_comb begin
      dist_d = bypass ? src_tick : vdiv_pulse;
   end

   // ****************************************************************
   // phase frequency detector and pump
   // ****************************************************************
   logic       up_q;
   logic       up_d;
   logic       dn_q;
   logic       dn_d;
   logic [2:0] abl_q;
   logic [2:0] abl_d;
   logic       pu_q;
   logic       pu_d;
   logic       pd_q;
   logic       pd_d;
   logic       hiz_q;
   logic       hiz_d;

   always_comb begin
      up_d  = up_q | (ref_pulse & ~pll_off);
      dn_d  = dn_q | (fb_tick_i & ~pll_off);
      abl_d = 3'h0;
      if (up_q & dn_q) begin
         // both sides held on for the antibacklash width, then reset together
         if (abl_q + 3'h1 >= abl_len) begin
            up_d = 1'b0;
            dn_d = 1'b0;
         end else begin
            abl_d = abl_q + 3'h1;
         end
      end
      if (pll_off) begin
         up_d = 1'b0;
         dn_d = 1'b0;
      end
      pu_d  = 1'b0;
      pd_d  = 1'b0;
      hiz_d = 1'b1;
      if (!pll_off) begin
         unique case (cp_mode)
            cpc_pkg::CP_NORMAL: begin
               hiz_d = 1'b0;
               pu_d  = pol_neg ? dn_q : up_q;
               pd_d  = pol_neg ? up_q : dn_q;
            end
            cpc_pkg::CP_PUMP_UP: begin
               hiz_d = 1'b0;
               pu_d  = 1'b1;
            end
            cpc_pkg::CP_PUMP_DOWN: begin
               hiz_d = 1'b0;
               pd_d  = 1'b1;
            end
            default: hiz_d = 1'b1;
         endcase
      end
   end

   // ****************************************************************
   // vco calibration
   // ****************************************************************
   typedef enum logic [0:0] {CAL_IDLE, CAL_RUN} cpc_cal_state_t;

   cpc_cal_state_t cal_st_q;
   cpc_cal_state_t cal_st_d;
   logic [15:0]    cal_cnt_q;
   logic [15:0]    cal_cnt_d;
   logic           done_q;
   logic           done_d;
   logic           cal_start;

   always_comb begin
      // only a committed zero-to-one change starts a new run
      cal_start = commit & sh_q.cal_ctrl[cpc_pkg::CAL_BIT] & ~act_q.cal_ctrl[cpc_pkg::CAL_BIT];
      cal_st_d  = cal_st_q;
      cal_cnt_d = cal_cnt_q;
      done_d    = done_q;
      if (commit & ~sh_q.cal_ctrl[cpc_pkg::CAL_BIT]) begin
         done_d = 1'b0;
      end
      unique case (cal_st_q)
         CAL_IDLE: begin
            if (cal_start) begin
               cal_st_d  = CAL_RUN;
               cal_cnt_d = 16'h0000;
               done_d    = 1'b0;
            end
         end
         CAL_RUN: begin
            // progress waits while the reference is absent
            if (ref_present_i) begin
               if (cal_cnt_q >= 16'(CAL_LEN - 1)) begin
                  cal_st_d = CAL_IDLE;
                  done_d   = 1'b1;
               end else begin
                  cal_cnt_d = cal_cnt_q + 16'h0001;
               end
            end
         end
      endcase
      status = {5'h00, ~pll_off, done_q, cal_st_q == CAL_RUN};
   end

   // ****************************************************************
   // datapath registers
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dist_q    <= 1'b0;
         up_q      <= 1'b0;
         dn_q      <= 1'b0;
         abl_q     <= 3'h0;
         pu_q      <= 1'b0;
         pd_q      <= 1'b0;
         hiz_q     <= 1'b1;
         cal_st_q  <= CAL_IDLE;
         cal_cnt_q <= 16'h0000;
         done_q    <= 1'b0;
      end else begin
         dist_q    <= dist_d;
         up_q      <= up_d;
         dn_q      <= dn_d;
         abl_q     <= abl_d;
         pu_q      <= pu_d;
         pd_q      <= pd_d;
         hiz_q     <= hiz_d;
         cal_st_q  <= cal_st_d;
         cal_cnt_q <= cal_cnt_d;
         done_q    <= done_d;
      end
   end

   assign pll_power_down_o = act_q.pll_ctrl[cpc_pkg::POWER_LSB];
   assign vco_select_o     = act_q.dist_sel[cpc_pkg::SRC_BIT];
   assign div_bypass_o     = act_q.dist_sel[cpc_pkg::BYPASS_BIT];
   assign vco_div_code_o   = act_q.vco_div[2:0];
   assign dist_tick_o      = dist_q;
   assign pump_up_o        = pu_q;
   assign pump_down_o      = pd_q;
   assign pump_hiz_o       = hiz_q;
   assign pump_current_o   = act_q.pump_cur[2:0];
   assign antibacklash_o   = act_q.abl_ctrl[1:0];
   assign cal_run_o        = cal_st_q == CAL_RUN;
   assign cal_done_o       = done_q;

endmodule

// ---- dv/cpc_clock_path_ctrl_chk.sv ----
`timescale 1ns/1ps
module cpc_clock_path_ctrl_chk #(
   parameter int CAL_LEN = cpc_pkg::CAL_CYCLES
) (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // clock path
   input wire logic        ref_tick_i,
   input wire logic        fb_tick_i,
   input wire logic        ext_clk_tick_i,
   input wire logic        vco_tick_i,
   input wire logic        ref_present_i,
   input wire logic        pll_power_down_o,
   input wire logic        vco_select_o,
   input wire logic        div_bypass_o,
   input wire logic [2:0]  vco_div_code_o,
   input wire logic        dist_tick_o,
   // detector, pump, calibration
   input wire logic        pump_up_o,
   input wire logic        pump_down_o,
   input wire logic        pump_hiz_o,
   input wire logic [2:0]  pump_current_o,
   input wire logic [1:0]  antibacklash_o,
   input wire logic        cal_run_o,
   input wire logic        cal_done_o
);
   logic upd_w;
   int   cal_cnt_q;
   int   cal_cnt_d;

   // update command taken at this edge
   assign upd_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
                  && wb_adr_i[11:2] == cpc_pkg::IDX_UPDATE && wb_dat_i[7:0] == cpc_pkg::UPDATE_CMD;

   always_comb begin
      cal_cnt_d = cal_cnt_q;
      if (!cal_run_o) begin
         cal_cnt_d = 0;
      end else if (ref_present_i) begin
         cal_cnt_d = cal_cnt_q + 1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cal_cnt_q <= 0;
      end else begin
         cal_cnt_q <= cal_cnt_d;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   rst_values_a: assert property ($fell(rst_i) |-> pll_power_down_o && !vco_select_o && !div_bypass_o
      && vco_div_code_o == 3'h2 && pump_hiz_o) else $error("wrong reset outputs");
   commit_only_a: assert property (!(upd_w || $past(upd_w)) |=> $stable({vco_div_code_o, vco_select_o,
      div_bypass_o, pll_power_down_o, pump_current_o, antibacklash_o})) else $error("setting moved without update");
   hiz_quiet_a: assert property (pump_hiz_o |-> !pump_up_o && !pump_down_o) else $error("pump active in hiz");
   power_down_a: assert property (pll_power_down_o && $past(pll_power_down_o) && $past(pll_power_down_o, 2)
      |-> pump_hiz_o) else $error("pump live while powered down");
   bypass_path_a: assert property ($past(div_bypass_o) |-> dist_tick_o ==
      ($past(vco_select_o) ? $past(vco_tick_i) : $past(ext_clk_tick_i))) else $error("bypass path wrong");
   div_gap_a: assert property (!$past(div_bypass_o) && !div_bypass_o && $stable(vco_div_code_o) && dist_tick_o
      |=> !dist_tick_o) else $error("divided ticks adjacent");
   cal_len_a: assert property ($fell(cal_run_o) |-> cal_done_o && cal_cnt_q == CAL_LEN)
      else $error("calibration length wrong");
   cal_start_a: assert property ($rose(cal_run_o) |-> !cal_done_o && $past(upd_w))
      else $error("calibration start not on commit");
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
   localparam int CAL_N = 8;
   logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, ref_tick, fb_tick, ext_tick, vco_tick, ref_present;
   logic [11:0] wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat, wb_dat_o;
   logic        pll_power_down_o, vco_select_o, div_bypass_o, dist_tick_o, pump_up_o, pump_down_o, pump_hiz_o;
   logic        cal_run_o, cal_done_o;
   logic [2:0]  vco_div_code_o, pump_current_o;
   logic [1:0]  antibacklash_o;
   logic [7:0]  rd, msk [logic [9:0]], sh [logic [9:0]];
   logic [7:0]  pc [9] = '{8'h10, 8'h90, 8'h90, 8'h20, 8'h30, 8'h00, 8'h50, 8'h21, 8'h10};
   logic [7:0]  ds [9] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
   logic [2:0]  ex [9] = '{3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 3'h4, 3'h4, 3'h4, 3'h0};
   int          miscompares, checks_done, seed, cyc_n, n;

   cpc_clock_path_ctrl #(.CAL_LEN(CAL_N)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_tick_i(ref_tick),
      .fb_tick_i(fb_tick), .ext_clk_tick_i(ext_tick), .vco_tick_i(vco_tick), .ref_present_i(ref_present),
      .pll_power_down_o(pll_power_down_o), .vco_select_o(vco_select_o), .div_bypass_o(div_bypass_o),
      .vco_div_code_o(vco_div_code_o), .dist_tick_o(dist_tick_o), .pump_up_o(pump_up_o), .pump_down_o(pump_down_o),
      .pump_hiz_o(pump_hiz_o), .pump_current_o(pump_current_o), .antibacklash_o(antibacklash_o),
      .cal_run_o(cal_run_o), .cal_done_o(cal_done_o));

   // ************************************************
   // bench tasks
   // ************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [9:0] idx, input logic [7:0] d);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= we;
      wb_adr <= {idx, 2'b00};
      wb_dat <= {24'h0, d};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      rd = wb_dat_o[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic upd();
      wb(1'b1, cpc_pkg::IDX_UPDATE, cpc_pkg::UPDATE_CMD);
      repeat (2) @(posedge clk_i);
   endtask

   task automatic pulse(input logic is_ref);
      ref_tick <= is_ref;
      fb_tick  <= !is_ref;
      @(posedge clk_i);
      ref_tick <= 1'b0;
      fb_tick  <= 1'b0;
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         miscompares++;
         test_done();
      end
   end

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      seed = 56;
      {miscompares, checks_done, cyc_n} = '0;
      {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, ref_tick, fb_tick, ext_tick, vco_tick} = '0;
      rst_i = 1'b1;
      wb_sel = 4'hF;
      ref_present = 1'b1;
      msk[cpc_pkg::IDX_PLL_CTRL] = cpc_pkg::MSK_PLL_CTRL;
      msk[cpc_pkg::IDX_RDIV_LO] = cpc_pkg::MSK_RDIV_LO;
      msk[cpc_pkg::IDX_RDIV_HI] = cpc_pkg::MSK_RDIV_HI;
      msk[cpc_pkg::IDX_ABL_CTRL] = cpc_pkg::MSK_ABL_CTRL;
      msk[cpc_pkg::IDX_PUMP_CUR] = cpc_pkg::MSK_PUMP_CUR;
      msk[cpc_pkg::IDX_VCO_DIV] = cpc_pkg::MSK_VCO_DIV;
      msk[cpc_pkg::IDX_DIST_SEL] = cpc_pkg::MSK_DIST_SEL;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({pll_power_down_o, vco_select_o, div_bypass_o, vco_div_code_o, pump_hiz_o}, 7'h45);
      // shadow writes with random data, reserved bits read zero
      foreach (msk[i]) begin
         sh[i] = 8'($random(seed));
         if (i == cpc_pkg::IDX_DIST_SEL && sh[i][1]) sh[i][0] = 1'b0;
         wb(1'b1, i, sh[i]);
         sh[i] = sh[i] & msk[i];
      end
      wb_sel <= 4'hE;
      wb(1'b1, cpc_pkg::IDX_PUMP_CUR, ~sh[cpc_pkg::IDX_PUMP_CUR]);
      wb_sel <= 4'hF;
      foreach (msk[i]) begin
         wb(1'b0, i, 8'h00);
         chk(rd, sh[i]);
      end
      wb(1'b1, 10'h3FF, 8'hFF);
      wb(1'b0, 10'h3FF, 8'h00);
      chk(rd, 8'h00);
      wb(1'b0, cpc_pkg::IDX_UPDATE, 8'h00);
      chk(rd, 8'h00);
      chk({pll_power_down_o, vco_select_o, div_bypass_o, vco_div_code_o, pump_current_o}, 9'h110);
      upd();
      chk(pump_current_o, sh[cpc_pkg::IDX_PUMP_CUR]);
      chk(antibacklash_o, sh[cpc_pkg::IDX_ABL_CTRL]);
      chk(vco_div_code_o, sh[cpc_pkg::IDX_VCO_DIV]);
      chk({vco_select_o, div_bypass_o, pll_power_down_o},
          {sh[cpc_pkg::IDX_DIST_SEL][1:0], sh[cpc_pkg::IDX_PLL_CTRL][0]});
      // divider ratio per code, last pass bypassed
      ext_tick <= 1'b1;
      vco_tick <= 1'b1;
      for (int c = 0; c < 9; c++) begin
         wb(1'b1, cpc_pkg::IDX_VCO_DIV, 8'(c));
         wb(1'b1, cpc_pkg::IDX_DIST_SEL, {7'h00, c == 8});
         upd();
         repeat (8) @(posedge clk_i);
         while (dist_tick_o !== 1'b1) @(posedge clk_i);
         n = 1;
         @(posedge clk_i);
         while (dist_tick_o !== 1'b1) begin
            n++;
            @(posedge clk_i);
         end
         chk(n, c == 8 ? 1 : (c > 4 ? 6 : c + 2));
      end
      // pump modes, polarity and power-down
      wb(1'b1, cpc_pkg::IDX_PLL_CTRL, 8'h10);
      upd();
      pulse(1'b0);
      for (int k = 0; k < 9; k++) begin
         wb(1'b1, cpc_pkg::IDX_PLL_CTRL, pc[k]);
         wb(1'b1, cpc_pkg::IDX_DIST_SEL, ds[k]);
         upd();
         repeat (3) @(posedge clk_i);
         chk({pump_hiz_o, pump_up_o, pump_down_o}, ex[k]);
      end
      wb(1'b1, cpc_pkg::IDX_RDIV_LO, 8'h01);
      wb(1'b1, cpc_pkg::IDX_RDIV_HI, 8'h00);
      upd();
      pulse(1'b1);
      repeat (4) @(posedge clk_i);
      chk({pump_up_o, pump_down_o}, 2'h2);
      pulse(1'b0);
      repeat (10) @(posedge clk_i);
      chk({pump_up_o, pump_down_o}, 2'h0);
      // calibration twice, with a repeated commit in between
      for (int k = 0; k < 2; k++) begin
         wb(1'b1, cpc_pkg::IDX_CAL_CTRL, 8'h01);
         upd();
         chk(cal_run_o, 1'b1);
         repeat (CAL_N) @(posedge clk_i);
         chk({cal_run_o, cal_done_o}, 2'h1);
         wb(1'b0, cpc_pkg::IDX_STATUS, 8'h00);
         chk(rd, 8'h06);
         upd();
         chk({cal_run_o, cal_done_o}, 2'h1);
         wb(1'b1, cpc_pkg::IDX_CAL_CTRL, 8'h00);
         upd();
         chk(cal_done_o, 1'b0);
      end
      test_done();
   end
endmodule

bind cpc_clock_path_ctrl cpc_clock_path_ctrl_chk #(.CAL_LEN(CAL_LEN)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_tick_i(ref_tick_i),
   .fb_tick_i(fb_tick_i), .ext_clk_tick_i(ext_clk_tick_i), .vco_tick_i(vco_tick_i), .ref_present_i(ref_present_i),
   .pll_power_down_o(pll_power_down_o), .vco_select_o(vco_select_o), .div_bypass_o(div_bypass_o),
   .vco_div_code_o(vco_div_code_o), .dist_tick_o(dist_tick_o), .pump_up_o(pump_up_o), .pump_down_o(pump_down_o),
   .pump_hiz_o(pump_hiz_o), .pump_current_o(pump_current_o), .antibacklash_o(antibacklash_o),
   .cal_run_o(cal_run_o), .cal_done_o(cal_done_o));
